//--- bench/tb.sv
// Purpose: Self-checking bench of the modem and interrupt control block
// Assumes: Strap pin low at the first reset, high at the second
// Notes:   Datapath levels are driven straight from the bench
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, fifo_ready_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        cts_n, dsr_n, ri_n, cd_n, dtr_n_o, rts_n_o, tx_pin_o, irq_o, irq_oe_n_o;
  logic        tx_serial_i, rx_serial_o, line_err_i, rx_timeout_i, rx_avail_i;
  logic        tx_below_i, thr_load_i, xoff_det_i, baud_ce_o, sleep_en_o, xon_any_o;
  logic        fifo_en_o, rx_pin, clk_sel, auto_rts, flow_rts_n;
  logic [7:0]  flow_threshold_o, trigger_level_o, r;
  int          errors, n_checks;
  // ==========================================================
  // Design and far side
  umic_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
    .ri_n_i(ri_n), .cd_n_i(cd_n), .rx_pin_i(rx_pin), .clk_sel_pin_i(clk_sel),
    .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .tx_pin_o(tx_pin_o), .irq_o(irq_o),
    .irq_oe_n_o(irq_oe_n_o), .tx_serial_i(tx_serial_i), .rx_serial_o(rx_serial_o),
    .auto_rts_en_i(auto_rts), .flow_rts_n_i(flow_rts_n), .line_err_i(line_err_i),
    .rx_timeout_i(rx_timeout_i), .rx_avail_i(rx_avail_i), .tx_below_i(tx_below_i),
    .thr_load_i(thr_load_i), .xoff_det_i(xoff_det_i), .fifo_ready_i(fifo_ready_i),
    .baud_ce_o(baud_ce_o), .sleep_en_o(sleep_en_o), .xon_any_o(xon_any_o),
    .fifo_en_o(fifo_en_o), .flow_threshold_o(flow_threshold_o),
    .trigger_level_o(trigger_level_o)
  );
  umic_modem_model u_modem (
    .clk_i(clk_i), .dtr_n_i(dtr_n_o), .rts_n_i(rts_n_o), .cts_n_o(cts_n),
    .dsr_n_o(dsr_n), .ri_n_o(ri_n), .cd_n_o(cd_n)
  );
  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Classic cycle; holds the request until ack is sampled, then idles a cycle
  task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, a};
    {wb_sel_i, wb_dat_i} <= {4'h1, 24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask : acc
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), r, e);
  endtask : rchk
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // Clock and watchdog; the whole run needs well under a thousand cycles
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    tick(5000);
    errors++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = {4'h8, 10'h000};
    {wb_dat_i, fifo_ready_i, tx_serial_i, line_err_i} = {32'h0, 4'hF, 2'h0};
    {rx_timeout_i, rx_avail_i, tx_below_i, thr_load_i, xoff_det_i} = 5'h00;
    {errors, n_checks} = {32'h0, 32'h0};
    {rx_pin, clk_sel, auto_rts, flow_rts_n} = 4'h9;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rchk(umic_pkg::OFS_MLC, 8'h80);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    chk("pins", {5'h00, dtr_n_o, rts_n_o, irq_oe_n_o}, 8'h07);
    // Guarded fields refuse writes until the enhanced bit is set
    acc(1'b1, umic_pkg::OFS_MLC, 8'hE3);
    acc(1'b1, umic_pkg::OFS_IEN, 8'hF0);
    rchk(umic_pkg::OFS_MLC, 8'h83);
    rchk(umic_pkg::OFS_IEN, 8'h00);
    acc(1'b1, umic_pkg::OFS_EFC, 8'h10);
    acc(1'b1, umic_pkg::OFS_MLC, 8'h2B);
    rchk(umic_pkg::OFS_MLC, 8'h2B);
    tick(2);
    chk("outs", {3'h0, xon_any_o, irq_oe_n_o, baud_ce_o, dtr_n_o, rts_n_o}, 8'h14);
    // Modem line changes, each seen three cycles later
    u_modem.set_lines(4'h7);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'h11);
    rchk(umic_pkg::OFS_MLS, 8'h10);
    u_modem.set_lines(4'h5);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'h50);
    u_modem.set_lines(4'h7);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'h14);
    u_modem.set_lines(4'hA);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'hAB);
    u_modem.set_lines(4'hF);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'h0A);
    // Priority walk through the sources
    acc(1'b1, umic_pkg::OFS_IEN, 8'hFF);
    rchk(umic_pkg::OFS_IEN, 8'hFF);
    chk("sleep", {7'h00, sleep_en_o}, 8'h01);
    {line_err_i, rx_avail_i} <= 2'h3;
    tick(3);
    rchk(umic_pkg::OFS_ISI, 8'h06);
    chk("irq", {7'h00, irq_o}, 8'h01);
    line_err_i <= 1'b0;
    tick(2);
    rchk(umic_pkg::OFS_ISI, 8'h04);
    {rx_avail_i, rx_timeout_i} <= 2'h1;
    tick(2);
    rchk(umic_pkg::OFS_ISI, 8'h0C);
    {rx_timeout_i, tx_below_i} <= 2'h1;
    tick(2);
    rchk(umic_pkg::OFS_ISI, 8'h02);
    rchk(umic_pkg::OFS_ISI, 8'h20);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    tick(2);
    chk("irq", {7'h00, irq_o}, 8'h00);
    acc(1'b1, umic_pkg::OFS_IEN, 8'hFD);
    acc(1'b1, umic_pkg::OFS_IEN, 8'hFF);
    rchk(umic_pkg::OFS_ISI, 8'h02);
    // Re-arm again so that only the load pulse can clear it
    acc(1'b1, umic_pkg::OFS_IEN, 8'hFD);
    acc(1'b1, umic_pkg::OFS_IEN, 8'hFF);
    thr_load_i <= 1'b1;
    tick(1);
    thr_load_i <= 1'b0;
    tick(2);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    u_modem.set_lines(4'h7);
    tick(5);
    rchk(umic_pkg::OFS_ISI, 8'h00);
    u_modem.set_lines(4'hF);
    tick(5);
    rchk(umic_pkg::OFS_MLS, 8'h01);
    rchk(umic_pkg::OFS_ISI, 8'h20);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    xoff_det_i <= 1'b1;
    tick(1);
    xoff_det_i <= 1'b0;
    tick(2);
    rchk(umic_pkg::OFS_ISI, 8'h10);
    acc(1'b1, umic_pkg::OFS_MLC, 8'h29);
    tick(3);
    rchk(umic_pkg::OFS_ISI, 8'h20);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    // Masked source must stay silent
    acc(1'b1, umic_pkg::OFS_IEN, 8'h00);
    line_err_i <= 1'b1;
    tick(3);
    rchk(umic_pkg::OFS_ISI, 8'h01);
    chk("irq", {7'h00, irq_o}, 8'h00);
    line_err_i <= 1'b0;
    // Id is read-only and mirrors the FIFO enable
    acc(1'b1, umic_pkg::OFS_FSC, 8'h01);
    acc(1'b1, umic_pkg::OFS_ISI, 8'h00);
    rchk(umic_pkg::OFS_ISI, 8'hC1);
    acc(1'b1, umic_pkg::OFS_MLC, 8'h69);
    acc(1'b1, umic_pkg::OFS_FTR, 8'h5A);
    rchk(umic_pkg::OFS_FTR, 8'h5A);
    acc(1'b1, umic_pkg::OFS_TLR, 8'hC3);
    chk("tlr", trigger_level_o, 8'hC3);
    chk("ftr", flow_threshold_o, 8'h5A);
    acc(1'b1, umic_pkg::OFS_MLC, 8'h6D);
    rchk(umic_pkg::OFS_FRS, 8'h33);
    fifo_ready_i <= 4'h9;
    rchk(umic_pkg::OFS_FRS, 8'h21);
    // Flow control takes over the send-request pin; receive pin passes through
    {auto_rts, flow_rts_n, rx_pin} <= 3'h4;
    tick(3);
    chk("rts", {7'h00, rts_n_o}, 8'h00);
    chk("rxp", {7'h00, rx_serial_o}, 8'h00);
    auto_rts <= 1'b0;
    // Loopback: control bits feed status, pins go quiet
    acc(1'b1, umic_pkg::OFS_MLC, 8'h1F);
    tick(2);
    chk("loop", {4'h0, dtr_n_o, rts_n_o, tx_pin_o, irq_oe_n_o}, 8'h0F);
    chk("rxs", {7'h00, rx_serial_o}, 8'h00);
    tx_serial_i <= 1'b1;
    tick(1);
    chk("rxs", {7'h00, rx_serial_o}, 8'h01);
    acc(1'b0, umic_pkg::OFS_MLS, 8'h00);
    rchk(umic_pkg::OFS_MLS, 8'hF0);
    rchk(umic_pkg::OFS_FRS, 8'h00);
    rchk(6'h24, 8'h00);
    // Second reset with the strap high selects divide by one
    {clk_sel, rst_i} <= 2'h3;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rchk(umic_pkg::OFS_MLC, 8'h00);
    end_sim();
  end
endmodule : tb

//--- bench/umic_modem_model.sv
// Purpose: Behavioural modem standing on the far side of the channel
// Assumes: Status lines are active low and rest high between events
// Notes:   Lines move only by non-blocking assignment just after an edge
`timescale 1ns/1ps
module umic_modem_model (
  input  wire logic clk_i,
  input  wire logic dtr_n_i,
  input  wire logic rts_n_i,
  output logic      cts_n_o,
  output logic      dsr_n_o,
  output logic      ri_n_o,
  output logic      cd_n_o
);
  // ==========================================================
  // Line state
  // Idle modem: every status line inactive high
  initial begin
    {cts_n_o, dsr_n_o, ri_n_o, cd_n_o} = 4'hF;
  end
  // Lines as {cts, dsr, ri, cd}; caller sits right after a clock edge
  task automatic set_lines(input logic [3:0] v);
    {cts_n_o, dsr_n_o, ri_n_o, cd_n_o} <= v;
  endtask : set_lines
endmodule : umic_modem_model

//--- include/umic_pkg.sv
// Purpose: Shared constants of the modem and interrupt control block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Data sits in bits 7:0, upper bits read as zero
package umic_pkg;
  // ==========================================================
  // Register map
  localparam int          ADR_W    = 6;
  localparam logic [5:0]  OFS_MLC  = 6'h00;  // modem_line_control
  localparam logic [5:0]  OFS_MLS  = 6'h04;  // modem_line_status
  localparam logic [5:0]  OFS_IEN  = 6'h08;  // interrupt_enables
  localparam logic [5:0]  OFS_ISI  = 6'h0C;  // interrupt_source_id
  localparam logic [5:0]  OFS_EFC  = 6'h10;  // enhanced_feature_control
  localparam logic [5:0]  OFS_FSC  = 6'h14;  // fifo_setup_control
  localparam logic [5:0]  OFS_FTR  = 6'h18;  // flow_threshold_register
  localparam logic [5:0]  OFS_TLR  = 6'h1C;  // trigger_level_register
  localparam logic [5:0]  OFS_FRS  = 6'h20;  // fifo_ready_status
  // ==========================================================
  // Field positions
  localparam int MLC_DTR  = 0;
  localparam int MLC_RTS  = 1;
  localparam int MLC_FRDY = 2;
  localparam int MLC_IRQ  = 3;
  localparam int MLC_LOOP = 4;
  localparam int MLC_XANY = 5;
  localparam int MLC_TACC = 6;
  localparam int MLC_DIV4 = 7;
  localparam int IEN_RHR  = 0;
  localparam int IEN_THR  = 1;
  localparam int IEN_LSE  = 2;
  localparam int IEN_MDM  = 3;
  localparam int IEN_SLP  = 4;
  localparam int IEN_XOF  = 5;
  localparam int IEN_RTS  = 6;
  localparam int IEN_CTS  = 7;
  localparam int EFC_EN   = 4;
  localparam int FSC_EN   = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] MLC_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] LVL_RST = 8'h00;
  localparam logic [5:0] PIN_RST = 6'h3F;
  // ==========================================================
  // Source identification codes, bits 5:0
  localparam logic [5:0] ID_LSE  = 6'h06;
  localparam logic [5:0] ID_RTO  = 6'h0C;
  localparam logic [5:0] ID_RDA  = 6'h04;
  localparam logic [5:0] ID_THR  = 6'h02;
  localparam logic [5:0] ID_MDM  = 6'h00;
  localparam logic [5:0] ID_XOF  = 6'h10;
  localparam logic [5:0] ID_CRS  = 6'h20;
  localparam logic [5:0] ID_NONE = 6'h01;
  // ==========================================================
  // Prescaler
  localparam logic [1:0] DIV4_LAST = 2'h3;
endpackage : umic_pkg

//--- verilog/umic_ctrl.sv
// Purpose: Modem control, modem status and interrupt logic of one channel
// Assumes: 125 MHz clk_i, synchronous active-high reset, Wishbone slave
// Notes:   Function
// Function
// RULE1 - Control bit 0 drives terminal-ready low when set; loopback feeds status bit 5
// RULE2 - Control bit 1 drives request-to-send low when set; auto flow overrides it
// RULE3 - Control bit 2 enables FIFO-ready status; loopback feeds status bit 6
// RULE4 - Control bit 3 enables interrupt pin driver; loopback feeds status bit 7
// RULE5 - Control bit 4 selects loopback: control 3:0 into status, transmit into receive
// RULE6 - Control bit 5 enables any-character resume
// RULE7 - Control bit 6 opens access to threshold and trigger-level registers
// RULE8 - Control bit 7 selects divide by four; loads inverse clock-select pin at reset
// RULE9 - Control bits 7:5 are written only while enhanced enable is set
// RULE10 - Status bits 0,1,3 set on input change, clear on status read
// RULE11 - Status bit 2 sets on ring input rising, clears on status read
// RULE12 - Status bits 7:4 show inverted inputs, or control bits 3,2,0,1 in loopback
// RULE13 - Enable bits 3:0 gate receive, transmit, line-status and modem interrupts
// RULE14 - Enable bit 4 is sleep; bits 5,6,7 gate stop-char, send-request, clear-to-send
// RULE15 - Enable bits 7:4 are written only while enhanced enable is set
// RULE16 - Re-enabling transmit interrupt below threshold raises a fresh one
// RULE17 - Interrupt output asserts whenever an enabled condition is pending
// RULE18 - Identification bit 0 is 0 while pending, 1 when idle
// RULE19 - Identification bits 7:6 mirror FIFO enable; register is read-only
// RULE20 - Identification bit 4 flags stop character, bit 5 flags line rise
// RULE21 - Codes 06 line error, 0C timeout, 04 data available
// RULE22 - Codes 02 transmit, 00 modem, 10 stop character, 20 line rise
// RULE23 - Highest priority pending source is reported; next follows once serviced
`timescale 1ns/1ps
module umic_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cts_n_i,
  input  wire logic        dsr_n_i,
  input  wire logic        ri_n_i,
  input  wire logic        cd_n_i,
  input  wire logic        rx_pin_i,
  input  wire logic        clk_sel_pin_i,
  output logic             dtr_n_o,
  output logic             rts_n_o,
  output logic             tx_pin_o,
  output logic             irq_o,
  output logic             irq_oe_n_o,
  input  wire logic        tx_serial_i,
  output logic             rx_serial_o,
  input  wire logic        auto_rts_en_i,
  input  wire logic        flow_rts_n_i,
  input  wire logic        line_err_i,
  input  wire logic        rx_timeout_i,
  input  wire logic        rx_avail_i,
  input  wire logic        tx_below_i,
  input  wire logic        thr_load_i,
  input  wire logic        xoff_det_i,
  input  wire logic [3:0]  fifo_ready_i,
  output logic             baud_ce_o,
  output logic             sleep_en_o,
  output logic             xon_any_o,
  output logic             fifo_en_o,
  output logic [7:0]       flow_threshold_o,
  output logic [7:0]       trigger_level_o
);
  // ==========================================================
  // Pin synchronisers: {clk_sel, rx, cd, ri, dsr, cts}
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  // Not reset: the strap must reach the control bit while reset is held
  always_ff @(posedge clk_i) begin
    pin_meta <= {clk_sel_pin_i, rx_pin_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
    pin_sync <= pin_meta;
  end

  // ==========================================================
  // Register state
  logic [7:0] mlc;
  logic [7:0] ien;
  logic       enh_en;
  logic [3:0] delta;
  logic [3:0] prev_src;
  logic       thr_pend;
  logic       tx_below_q;
  logic       xoff_flag;
  logic       cts_flag;
  logic       rts_flag;
  logic       cts_q;
  logic       rts_q;
  logic [1:0] div_cnt;

  // ==========================================================
  // Bus decode; the slave answers one cycle after the request
  wire req     = wb_cyc_i & wb_stb_i;
  wire rd_take = req & ~wb_we_i & ~wb_ack_o;
  wire wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire hit_mlc = (wb_adr_i == umic_pkg::OFS_MLC);
  wire hit_mls = (wb_adr_i == umic_pkg::OFS_MLS);
  wire hit_ien = (wb_adr_i == umic_pkg::OFS_IEN);
  wire hit_isi = (wb_adr_i == umic_pkg::OFS_ISI);
  wire hit_efc = (wb_adr_i == umic_pkg::OFS_EFC);
  wire hit_fsc = (wb_adr_i == umic_pkg::OFS_FSC);
  wire hit_ftr = (wb_adr_i == umic_pkg::OFS_FTR);
  wire hit_tlr = (wb_adr_i == umic_pkg::OFS_TLR);
  wire hit_frs = (wb_adr_i == umic_pkg::OFS_FRS);
  wire [7:0] wdat  = wb_dat_i[7:0];
  wire       loop  = mlc[umic_pkg::MLC_LOOP];
  wire       lvl_ok = mlc[umic_pkg::MLC_TACC];                    // RULE7
  wire       lvl_wr = wr_fire & enh_en & lvl_ok;                  // RULE7

  // ==========================================================
  // Modem status: live levels {cd, ri, dsr, cts}, active high
  wire [3:0] pin_src = ~pin_sync[3:0];                            // RULE12
  wire [3:0] lb_src  = {mlc[umic_pkg::MLC_IRQ], mlc[umic_pkg::MLC_FRDY],
                        mlc[umic_pkg::MLC_DTR], mlc[umic_pkg::MLC_RTS]};
  wire [3:0] src     = loop ? lb_src : pin_src;                   // RULE5 RULE12
  // Ring sets only when its pin goes low to high, i.e. level falls
  wire [3:0] chg     = {src[3] ^ prev_src[3], ~src[2] & prev_src[2],
                        src[1] ^ prev_src[1], src[0] ^ prev_src[0]}; // RULE10 RULE11
  wire       msr_rd  = rd_take & hit_mls;
  wire [7:0] msr_val = {src, delta};

  // ==========================================================
  // Interrupt sources, highest priority first
  wire p_lse = line_err_i & ien[umic_pkg::IEN_LSE];               // RULE13
  wire p_rto = rx_timeout_i & ien[umic_pkg::IEN_RHR];             // RULE13
  wire p_rda = rx_avail_i & ien[umic_pkg::IEN_RHR];               // RULE13
  wire p_thr = thr_pend & ien[umic_pkg::IEN_THR];                 // RULE13
  wire p_mdm = (|delta) & ien[umic_pkg::IEN_MDM];                 // RULE13
  wire p_xof = xoff_flag & ien[umic_pkg::IEN_XOF];                // RULE14
  wire p_crs = (cts_flag & ien[umic_pkg::IEN_CTS]) |
               (rts_flag & ien[umic_pkg::IEN_RTS]);               // RULE14
  wire any_pend = p_lse | p_rto | p_rda | p_thr | p_mdm | p_xof | p_crs;
  // Fixed priority chain; a lower source shows once higher ones clear
  wire [5:0] id_code = p_lse ? umic_pkg::ID_LSE :                 // RULE21 RULE23
                       p_rto ? umic_pkg::ID_RTO :                 // RULE21
                       p_rda ? umic_pkg::ID_RDA :                 // RULE21
                       p_thr ? umic_pkg::ID_THR :                 // RULE22
                       p_mdm ? umic_pkg::ID_MDM :                 // RULE22
                       p_xof ? umic_pkg::ID_XOF :                 // RULE20 RULE22
                       p_crs ? umic_pkg::ID_CRS :                 // RULE20 RULE22
                               umic_pkg::ID_NONE;                 // RULE18
  wire [7:0] isi_val = {{2{fifo_en_o}}, id_code};                 // RULE19
  wire       isi_rd  = rd_take & hit_isi;
  // Reading the identification services the transient sources it names
  wire clr_thr = (isi_rd & (id_code == umic_pkg::ID_THR)) | thr_load_i;
  wire clr_xof = isi_rd & (id_code == umic_pkg::ID_XOF);
  wire clr_crs = isi_rd & (id_code == umic_pkg::ID_CRS);
  wire tx_rise = tx_below_i & ~tx_below_q;
  wire ien1_re = wr_fire & hit_ien & wdat[umic_pkg::IEN_THR] & ~ien[umic_pkg::IEN_THR];
  wire set_thr = tx_rise | (ien1_re & tx_below_i);                // RULE16
  wire cts_up  = pin_sync[0] & ~cts_q;                            // RULE20
  wire rts_up  = rts_n_o & ~rts_q;                                // RULE20

  // ==========================================================
  // Read multiplexer; unmapped or closed words read as zero
  wire [7:0] ftr_rd = lvl_ok ? flow_threshold_o : 8'h00;
  wire [7:0] tlr_rd = lvl_ok ? trigger_level_o : 8'h00;
  wire       frs_ok = mlc[umic_pkg::MLC_FRDY] & ~loop;            // RULE3
  wire [7:0] frs_rd = frs_ok ? {2'h0, fifo_ready_i[3:2], 2'h0, fifo_ready_i[1:0]} : 8'h00;
  wire [7:0] efc_rd = {3'h0, enh_en, 4'h0};
  wire [7:0] fsc_rd = {7'h00, fifo_en_o};
  wire [7:0] rd_mux = hit_mlc ? mlc :
                      hit_mls ? msr_val :
                      hit_ien ? ien :
                      hit_isi ? isi_val :
                      hit_efc ? efc_rd :
                      hit_fsc ? fsc_rd :
                      hit_ftr ? ftr_rd :
                      hit_tlr ? tlr_rd :
                      hit_frs ? frs_rd : 8'h00;

  // Ack and read data; read data is sampled at the taking edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (rd_take) begin
        wb_dat_o <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ==========================================================
  // Modem control; bits 7:5 guarded, bit 7 tracks the strap in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mlc <= {~pin_sync[5], umic_pkg::MLC_RST[6:0]};              // RULE8
    end else if (wr_fire & hit_mlc) begin
      mlc[4:0] <= wdat[4:0];
      if (enh_en) begin
        mlc[7:5] <= wdat[7:5];                                    // RULE9
      end
    end
  end

  // Interrupt enables; upper nibble guarded by enhanced enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien <= umic_pkg::IEN_RST;
    end else if (wr_fire & hit_ien) begin
      ien[3:0] <= wdat[3:0];                                      // RULE13
      if (enh_en) begin
        ien[7:4] <= wdat[7:4];                                    // RULE15
      end
    end
  end

  // Enhanced enable, FIFO enable and gated level registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enh_en           <= 1'b0;
      fifo_en_o        <= 1'b0;
      flow_threshold_o <= umic_pkg::LVL_RST;
      trigger_level_o  <= umic_pkg::LVL_RST;
    end else begin
      if (wr_fire & hit_efc) begin
        enh_en <= wdat[umic_pkg::EFC_EN];
      end
      if (wr_fire & hit_fsc) begin
        fifo_en_o <= wdat[umic_pkg::FSC_EN];
      end
      if (lvl_wr & hit_ftr) begin
        flow_threshold_o <= wdat;                                 // RULE7
      end
      if (lvl_wr & hit_tlr) begin
        trigger_level_o <= wdat;                                  // RULE7
      end
    end
  end

  // ==========================================================
  // Delta bits: a change in the read cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delta    <= 4'h0;
      prev_src <= 4'h0;
    end else begin
      prev_src <= src;
      delta    <= (delta & {4{~msr_rd}}) | chg;                   // RULE10 RULE11
    end
  end

  // Sticky interrupt flags; every set wins over its clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_pend   <= 1'b0;
      tx_below_q <= 1'b0;
      xoff_flag  <= 1'b0;
      cts_flag   <= 1'b0;
      rts_flag   <= 1'b0;
      cts_q      <= 1'b1;
      rts_q      <= 1'b1;
    end else begin
      tx_below_q <= tx_below_i;
      cts_q      <= pin_sync[0];
      rts_q      <= rts_n_o;
      thr_pend   <= (thr_pend & ~clr_thr) | set_thr;              // RULE16
      xoff_flag  <= (xoff_flag & ~clr_xof) | xoff_det_i;          // RULE20
      cts_flag   <= (cts_flag & ~clr_crs) | cts_up;               // RULE20
      rts_flag   <= (rts_flag & ~clr_crs) | rts_up;               // RULE20
    end
  end

  // ==========================================================
  // Modem outputs, registered; loopback parks dtr_n_o and irq_oe_n_o inactive, and rts_n_o unless auto flow drives it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtr_n_o    <= 1'b1;
      rts_n_o    <= 1'b1;
      irq_o      <= 1'b0;
      irq_oe_n_o <= 1'b1;
    end else begin
      dtr_n_o    <= loop | ~mlc[umic_pkg::MLC_DTR];               // RULE1
      rts_n_o    <= auto_rts_en_i ? flow_rts_n_i :                // RULE2
                    (loop | ~mlc[umic_pkg::MLC_RTS]);             // RULE2
      irq_o      <= any_pend;                                     // RULE17
      irq_oe_n_o <= ~mlc[umic_pkg::MLC_IRQ] | loop;               // RULE4
    end
  end

  // Serial loopback keeps the line idle while looped
  assign tx_pin_o    = loop ? 1'b1 : tx_serial_i;                 // RULE5
  assign rx_serial_o = loop ? tx_serial_i : pin_sync[4];          // RULE5
  assign sleep_en_o  = ien[umic_pkg::IEN_SLP];                    // RULE14
  assign xon_any_o   = mlc[umic_pkg::MLC_XANY];                   // RULE6

  // ==========================================================
  // Prescale enable: every cycle, or every fourth when divided
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt   <= 2'h0;
      baud_ce_o <= 1'b0;
    end else begin
      div_cnt   <= 2'(div_cnt + 2'h1);
      baud_ce_o <= ~mlc[umic_pkg::MLC_DIV4] | (div_cnt == umic_pkg::DIV4_LAST); // RULE8
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ien1_rearm;
    ien1_re && tx_below_i;
  endsequence
  sequence s_thr_report;
    thr_pend && ien[umic_pkg::IEN_THR] && !p_lse && !p_rto && !p_rda;
  endsequence

  property p_dtr_drive;
    !loop |=> dtr_n_o == !$past(mlc[umic_pkg::MLC_DTR]);
  endproperty
  a_dtr_drive: assert property (p_dtr_drive) else $error("dtr level wrong"); // RULE1

  property p_rts_manual;
    !auto_rts_en_i && !loop |=> rts_n_o == !$past(mlc[umic_pkg::MLC_RTS]);
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts level wrong"); // RULE2

  property p_rts_auto;
    auto_rts_en_i |=> rts_n_o == $past(flow_rts_n_i);
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts not under flow control"); // RULE2

  property p_irq_hiz;
    !mlc[umic_pkg::MLC_IRQ] |=> irq_oe_n_o;
  endproperty
  a_irq_hiz: assert property (p_irq_hiz) else $error("irq driven while off"); // RULE4

  property p_loop_map;
    loop |-> msr_val[7:4] == {mlc[3], mlc[2], mlc[0], mlc[1]} && rx_serial_o == tx_serial_i;
  endproperty
  a_loop_map: assert property (p_loop_map) else $error("loopback map wrong"); // RULE5

  property p_msr_clear;
    msr_rd |=> delta == $past(chg);
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("delta not cleared"); // RULE10

  property p_mlc_guard;
    wr_fire && hit_mlc && !enh_en |=> mlc[7:5] == $past(mlc[7:5]);
  endproperty
  a_mlc_guard: assert property (p_mlc_guard) else $error("guarded bits moved"); // RULE9

  property p_ien_guard;
    wr_fire && hit_ien && !enh_en |=> ien[7:4] == $past(ien[7:4]);
  endproperty
  a_ien_guard: assert property (p_ien_guard) else $error("enable bits moved"); // RULE15

  property p_thr_rearm;
    s_ien1_rearm |=> thr_pend && ien[umic_pkg::IEN_THR];
  endproperty
  a_thr_rearm: assert property (p_thr_rearm) else $error("no fresh tx int"); // RULE16

  property p_thr_report;
    s_thr_report |-> id_code == umic_pkg::ID_THR;
  endproperty
  a_thr_report: assert property (p_thr_report) else $error("tx int not reported"); // RULE23

  property p_irq_follow;
    any_pend |=> irq_o;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not raised"); // RULE17

  property p_idle_code;
    !any_pend |-> id_code == umic_pkg::ID_NONE ##1 !irq_o;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle code wrong"); // RULE18

  property p_top_prio;
    p_lse |-> id_code == umic_pkg::ID_LSE;
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("priority wrong"); // RULE21

  property p_div4;
    // Looks back, so a later write to the divide bit cannot trip it
    mlc[umic_pkg::MLC_DIV4] && $past(mlc[umic_pkg::MLC_DIV4]) && baud_ce_o &&
      $past(mlc[umic_pkg::MLC_DIV4], 2) && $past(mlc[umic_pkg::MLC_DIV4], 3) &&
      $past(mlc[umic_pkg::MLC_DIV4], 4)
      |-> !$past(baud_ce_o) && !$past(baud_ce_o, 2) && !$past(baud_ce_o, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("prescale wrong"); // RULE8

endmodule : umic_ctrl
